/* File: core/fir_params.svh */
`ifndef FIR_PARAMS_SVH
`define FIR_PARAMS_SVH

// memory geometry
`define FIR_MEM_BYTES      8192
`define FIR_ADDR_W         13
// slave address byte layout
`define FIR_TYPE_MSB       7
`define FIR_TYPE_LSB       4
`define FIR_SEL_MSB        3
`define FIR_SEL_LSB        1
`define FIR_RW_BIT         0
// arbitrary device-type code, not any real part's
`define FIR_DEV_TYPE       4'h6
// high-speed master code pattern 0000_1xxx
`define FIR_HS_CODE        5'h01
`define FIR_HS_CODE_MSB    7
`define FIR_HS_CODE_LSB    3
// bits per byte on the wire
`define FIR_BITS           4'h8
`define FIR_LAST_TX_BIT    4'h7
// write byte index: word-address high, word-address low, then data
`define FIR_IDX_HI         2'h0
`define FIR_IDX_LO         2'h1
`define FIR_IDX_DATA       2'h2
// buffer
`define FIR_BUF_DEPTH      2

`endif

/* File: core/fir_pkg.sv */
package fir_pkg;

  typedef enum logic [2:0] {
    FIR_IDLE      = 3'h0,
    FIR_ADDR      = 3'h1,
    FIR_ACK_ADDR  = 3'h3,
    FIR_TX        = 3'h2,
    FIR_ACK_TX    = 3'h6,
    FIR_RX        = 3'h7,
    FIR_ACK_RX    = 3'h5,
    FIR_WAIT_STOP = 3'h4
  } fir_state_t;

endpackage

/* File: core/fir_read_slave.sv */
// How it works
// R1 - current read uses internal address register
// R2 - after reading n, next read gives n+1
// R3 - after writing n, current read gives n
// R4 - master should stop before current read
// R5 - address register undefined after power-up
// R6 - random read: address write, restart, read
// R7 - master ack without stop: send next byte
// R8 - sequential read wraps highest to lowest
// R9 - master sends high-speed code first
// R10 - high-speed mode lasts until next stop
// R11 - host keeps lines high around power changes
// R12 - address advances after each output byte
// R13 - address byte: type, select bits, direction
// R14 - acknowledge low on matching slave address
// R15 - no ack after byte: release, await stop
// R16 - 8192 locations, wrap at that boundary
`timescale 1ns/1ps
`include "fir_params.svh"

module fir_read_slave #(
  parameter int AW = `FIR_ADDR_W
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          scl_i,
  input  wire logic          sda_i,
  output logic               sda_o,
  output logic               sda_oe,
  input  wire logic [2:0]    device_select_pins,
  output logic               hs_mode,
  output logic               fetch_valid,
  output logic [AW-1:0]      fetch_addr,
  input  wire logic          src_valid,
  input  wire logic [7:0]    src_data,
  output logic               src_ready,
  output logic               wr_valid,
  output logic [AW-1:0]      wr_addr,
  output logic [7:0]         wr_data
);

  // input synchroniser: scl, sda, select pins; filtered value moves when stages 2 and 3 agree
  logic [4:0] s1_r, s2_r, s3_r, flt_r, prev_r;
  logic [4:0] flt_nxt;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      flt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : flt_r[i];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_r   <= 5'h03;
      s2_r   <= 5'h03;
      s3_r   <= 5'h03;
      flt_r  <= 5'h03;
      prev_r <= 5'h03;
    end else begin
      s1_r   <= {device_select_pins, sda_i, scl_i};
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      flt_r  <= flt_nxt;
      prev_r <= flt_r;
    end
  end
  logic scl_f, sda_f, scl_rise, scl_fall, start_det, stop_det;
  assign scl_f     = flt_r[0];
  assign sda_f     = flt_r[1];
  assign scl_rise  = scl_f & ~prev_r[0];
  assign scl_fall  = ~scl_f & prev_r[0];
  assign start_det = scl_f & prev_r[0] & prev_r[1] & ~sda_f;
  assign stop_det  = scl_f & prev_r[0] & ~prev_r[1] & sda_f;
  // two-entry read-data buffer between memory side and shifter
  logic [7:0] buf_r [`FIR_BUF_DEPTH];
  logic [7:0] buf_nxt [`FIR_BUF_DEPTH];
  logic       wp_r, rp_r, wp_nxt, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic       src_ready_r, src_ready_nxt;
  logic       push, pop, buf_valid;
  assign push      = src_valid & src_ready_r;
  assign buf_valid = (cnt_r != 2'h0);
  always_comb begin
    buf_nxt = buf_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (start_det || stop_det) begin
      wp_nxt  = 1'b0;
      rp_nxt  = 1'b0;
      cnt_nxt = 2'h0;
    end else begin
      if (push) begin
        buf_nxt[wp_r] = src_data;
        wp_nxt        = ~wp_r;
      end
      if (pop) begin
        rp_nxt = ~rp_r;
      end
      cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    end
    src_ready_nxt = (cnt_nxt != 2'h2);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      buf_r[0]    <= 8'h00;
      buf_r[1]    <= 8'h00;
      wp_r        <= 1'b0;
      rp_r        <= 1'b0;
      cnt_r       <= 2'h0;
      src_ready_r <= 1'b1;
    end else begin
      buf_r       <= buf_nxt;
      wp_r        <= wp_nxt;
      rp_r        <= rp_nxt;
      cnt_r       <= cnt_nxt;
      src_ready_r <= src_ready_nxt;
    end
  end
  // protocol engine
  fir_pkg::fir_state_t st_r, st_nxt;
  logic [3:0]    bit_r, bit_nxt;
  logic [7:0]    sh_r, sh_nxt;
  logic          rw_r, rw_nxt;
  logic [1:0]    idx_r, idx_nxt;
  logic          hs_r, hs_nxt;
  logic          oe_r, oe_nxt;
  logic          fv_r, fv_nxt;
  logic [AW-1:0] fa_r, fa_nxt;
  logic          wv_r, wv_nxt;
  logic [AW-1:0] wa_r, wa_nxt;
  logic [7:0]    wd_r, wd_nxt;
  logic          wpend_r, wpend_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [AW-1:0] waddr;
  logic [7:0]    rx_byte;
  logic          match;
  assign rx_byte = sh_r;
  assign match   = (rx_byte[`FIR_TYPE_MSB:`FIR_TYPE_LSB] == `FIR_DEV_TYPE) &&
                   (rx_byte[`FIR_SEL_MSB:`FIR_SEL_LSB] == flt_r[4:2]);    // R13
  assign waddr   = wpend_r ? addr_r + 1'b1 : addr_r;                      // R3
  always_comb begin
    st_nxt    = st_r;
    bit_nxt   = bit_r;
    sh_nxt    = sh_r;
    rw_nxt    = rw_r;
    idx_nxt   = idx_r;
    hs_nxt    = hs_r;
    oe_nxt    = oe_r;
    fv_nxt    = 1'b0;
    fa_nxt    = fa_r;
    wv_nxt    = 1'b0;
    wa_nxt    = wa_r;
    wd_nxt    = wd_r;
    wpend_nxt = wpend_r;
    addr_nxt  = addr_r;
    pop       = 1'b0;
    if (stop_det) begin
      st_nxt = fir_pkg::FIR_IDLE;
      oe_nxt = 1'b0;
      hs_nxt = 1'b0;                                                      // R10
    end else if (start_det) begin
      st_nxt  = fir_pkg::FIR_ADDR;
      bit_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end else begin
      unique case (st_r)
        fir_pkg::FIR_IDLE, fir_pkg::FIR_WAIT_STOP: begin
          oe_nxt = 1'b0;
        end
        fir_pkg::FIR_ADDR, fir_pkg::FIR_RX: begin
          if (scl_rise && bit_r != `FIR_BITS) begin
            sh_nxt  = {sh_r[6:0], sda_f};
            bit_nxt = bit_r + 4'h1;
          end else if (scl_fall && bit_r == `FIR_BITS) begin
            if (st_r == fir_pkg::FIR_RX) begin
              oe_nxt = 1'b1;
              st_nxt = fir_pkg::FIR_ACK_RX;
              if (idx_r == `FIR_IDX_HI) begin
                addr_nxt[AW-1:8] = rx_byte[AW-9:0];
              end else if (idx_r == `FIR_IDX_LO) begin
                addr_nxt[7:0] = rx_byte;
                wpend_nxt     = 1'b0;
              end else begin
                addr_nxt  = waddr;
                wa_nxt    = waddr;
                wd_nxt    = rx_byte;
                wv_nxt    = 1'b1;
                wpend_nxt = 1'b1;
              end
              if (idx_r != `FIR_IDX_DATA) begin
                idx_nxt = idx_r + 2'h1;
              end
            end else if (match) begin
              oe_nxt = 1'b1;                                              // R14
              rw_nxt = rx_byte[`FIR_RW_BIT];
              st_nxt = fir_pkg::FIR_ACK_ADDR;
              if (rx_byte[`FIR_RW_BIT]) begin
                fv_nxt = 1'b1;                                            // R1
                fa_nxt = addr_r;
              end
            end else begin
              if (rx_byte[`FIR_HS_CODE_MSB:`FIR_HS_CODE_LSB] == `FIR_HS_CODE) begin
                hs_nxt = 1'b1;                                            // R10
              end
              st_nxt = fir_pkg::FIR_WAIT_STOP;
            end
          end
        end
        fir_pkg::FIR_ACK_ADDR, fir_pkg::FIR_ACK_RX: begin
          if (scl_fall) begin
            bit_nxt = 4'h0;
            if (st_r == fir_pkg::FIR_ACK_ADDR && rw_r) begin
              pop      = buf_valid;
              sh_nxt   = buf_r[rp_r];
              oe_nxt   = ~buf_r[rp_r][7];
              addr_nxt = addr_r + 1'b1;                                   // R12 R2 R16
              st_nxt   = fir_pkg::FIR_TX;
            end else begin
              oe_nxt = 1'b0;
              if (st_r == fir_pkg::FIR_ACK_ADDR) begin
                idx_nxt = `FIR_IDX_HI;
              end
              st_nxt = fir_pkg::FIR_RX;
            end
          end
        end
        fir_pkg::FIR_TX: begin
          if (scl_fall) begin
            if (bit_r == `FIR_LAST_TX_BIT) begin
              oe_nxt = 1'b0;
              st_nxt = fir_pkg::FIR_ACK_TX;
            end else begin
              sh_nxt  = {sh_r[6:0], 1'b0};
              oe_nxt  = ~sh_r[6];
              bit_nxt = bit_r + 4'h1;
            end
          end
        end
        fir_pkg::FIR_ACK_TX: begin
          if (scl_rise) begin
            if (!sda_f) begin
              fv_nxt = 1'b1;                                              // R7 R8
              fa_nxt = addr_r;
              st_nxt = fir_pkg::FIR_ACK_ADDR;
            end else begin
              st_nxt = fir_pkg::FIR_WAIT_STOP;                            // R15
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= fir_pkg::FIR_IDLE;
      bit_r   <= 4'h0;
      sh_r    <= 8'h00;
      rw_r    <= 1'b0;
      idx_r   <= 2'h0;
      hs_r    <= 1'b0;
      oe_r    <= 1'b0;
      fv_r    <= 1'b0;
      fa_r    <= '0;
      wv_r    <= 1'b0;
      wa_r    <= '0;
      wd_r    <= 8'h00;
      wpend_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      bit_r   <= bit_nxt;
      sh_r    <= sh_nxt;
      rw_r    <= rw_nxt;
      idx_r   <= idx_nxt;
      hs_r    <= hs_nxt;
      oe_r    <= oe_nxt;
      fv_r    <= fv_nxt;
      fa_r    <= fa_nxt;
      wv_r    <= wv_nxt;
      wa_r    <= wa_nxt;
      wd_r    <= wd_nxt;
      wpend_r <= wpend_nxt;
    end
  end
  // address register deliberately has no reset: its content is undefined at power-up
  always_ff @(posedge clk_sys) begin
    addr_r <= addr_nxt;                                                   // R5
  end

  assign sda_o       = 1'b0;
  assign sda_oe      = oe_r;
  assign hs_mode     = hs_r;
  assign fetch_valid = fv_r;
  assign fetch_addr  = fa_r;
  assign src_ready   = src_ready_r;
  assign wr_valid    = wv_r;
  assign wr_addr     = wa_r;
  assign wr_data     = wd_r;

endmodule

/* File: dv/fir_mem_model.sv */
`timescale 1ns/1ps
module fir_mem_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        fetch_valid,
  input  wire logic [12:0] fetch_addr,
  input  wire logic        src_ready,
  output logic             src_valid,
  output logic [7:0]       src_data
);
  // byte content is a fixed function of its address; released data shows its inverse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_valid <= 1'b0;
      src_data  <= 8'h00;
    end else if (fetch_valid) begin
      src_valid <= 1'b1;
      src_data  <= fetch_addr[7:0] ^ {3'h0, fetch_addr[12:8]};
    end else if (src_valid && src_ready) begin
      src_valid <= 1'b0;
      src_data  <= ~src_data;
    end
  end
endmodule

/* File: dv/fir_read_slave_chk.sv */
`timescale 1ns/1ps
module fir_read_slave_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        hs_mode,
  input wire logic        fetch_valid,
  input wire logic [12:0] fetch_addr,
  input wire logic        wr_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_sda_open_drain: assert property (sda_o == 1'b0) else $error("sda driven high");
  a_fetch_one_pulse: assert property (fetch_valid |=> !fetch_valid) else $error("fetch long");
  a_wr_one_pulse: assert property (wr_valid |=> !wr_valid) else $error("write long");
  a_ack_on_low: assert property ($rose(sda_oe) |-> !scl_i) else $error("drive while clk high");
  a_oe_steady_high: assert property (scl_i && $past(scl_i, 6) |-> !$rose(sda_oe))
    else $error("drive in high phase");
  a_hs_ends_stop: assert property ($fell(hs_mode) |-> scl_i) else $error("hs left off stop");
  a_fetch_addr_held: assert property (!fetch_valid |-> $stable(fetch_addr))
    else $error("fetch address moved");
  a_wr_on_low: assert property (wr_valid |-> !scl_i && !fetch_valid) else $error("bad write");
endmodule

bind fir_read_slave fir_read_slave_chk chk (.clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .hs_mode(hs_mode), .fetch_valid(fetch_valid),
  .fetch_addr(fetch_addr), .wr_valid(wr_valid));

/* File: dv/fir_read_slave_test.sv */
`timescale 1ns/1ps
module fir_read_slave_test;
  logic        clk_sys, rst_n, scl_m, sda_m, sda_w, sda_o, sda_oe, hs_mode, ak;
  logic        fetch_valid, src_valid, src_ready, wr_valid;
  logic [12:0] fetch_addr, wr_addr, wa;
  logic [7:0]  src_data, wr_data, wd, rb;
  logic [2:0]  sel;
  int          errors, check_count;
  logic [12:0] row_a [3] = '{13'h0005, 13'h1ffe, 13'h0abc};
  int          row_n [3] = '{1, 3, 2};
  logic [7:0]  row_d [3] = '{8'h05, 8'he1, 8'hb6};
  // open-drain wire: low if either side pulls
  assign sda_w = sda_m & ~sda_oe;
  fir_read_slave dut (.clk_sys(clk_sys), .rst_n(rst_n), .scl_i(scl_m), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .device_select_pins(sel), .hs_mode(hs_mode),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .src_valid(src_valid),
    .src_data(src_data), .src_ready(src_ready), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data));
  fir_mem_model mem (.clk_sys(clk_sys), .rst_n(rst_n), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .src_ready(src_ready), .src_valid(src_valid), .src_data(src_data));
  always @(posedge clk_sys) if (wr_valid) begin
    wa <= wr_addr;
    wd <= wr_data;
  end
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] fx(logic [12:0] a);
    return a[7:0] ^ {3'h0, a[12:8]};
  endfunction
  task automatic chk(logic [12:0] got, logic [12:0] exp, string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic q(int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic bit_io(logic b, output logic r);
    sda_m = b; q(10); scl_m = 1'b1; q(10); r = sda_w; q(10); scl_m = 1'b0; q(10);
  endtask
  task automatic start();
    sda_m = 1'b1; scl_m = 1'b1; q(10); sda_m = 1'b0; q(10); scl_m = 1'b0; q(10);
  endtask
  task automatic stop();
    sda_m = 1'b0; q(10); scl_m = 1'b1; q(10); sda_m = 1'b1; q(20);
  endtask
  task automatic send(logic [7:0] b, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    a = !r;
  endtask
  task automatic recv(logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(!mack, r);
  endtask
  // optional address phase, then a (repeated) start and n bytes, nack on the last
  task automatic rd(logic [12:0] a, int n, logic rnd, logic [7:0] e0);
    if (rnd) begin
      start();
      send(8'h6a, ak);
      chk(ak, 1, "write select ack");
      send({3'h0, a[12:8]}, ak);
      chk(ak, 1, "address high ack");
      send(a[7:0], ak);
      chk(ak, 1, "address ack");
    end
    start();
    send(8'h6b, ak);
    chk(ak, 1, "read select ack");
    for (int i = 0; i < n; i++) begin
      recv(i < n - 1, rb);
      chk(rb, i == 0 ? e0 : fx(a + i), "read byte");
    end
    stop();
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    scl_m = 1'b1;
    sda_m = 1'b1;
    sel = 3'h5;
    errors = 0;
    check_count = 0;
    repeat (6) @(negedge clk_sys);
    chk({sda_oe, hs_mode, fetch_valid, src_ready}, 4'h1, "reset values");
    rst_n = 1'b1; q(8);
    $display("reset test done");
    for (int i = 0; i < 3; i++) rd(row_a[i], row_n[i], 1'b1, row_d[i]);
    $display("table test done");
    rd(13'h0abe, 1, 1'b0, fx(13'h0abe));
    start();
    send(8'h6a, ak);
    send(8'h01, ak);
    send(8'h23, ak);
    send(8'h5a, ak);
    chk(ak, 1, "write data ack");
    stop();
    chk(wa, 13'h0123, "write address");
    chk(wd, 8'h5a, "write data");
    rd(13'h0123, 1, 1'b0, fx(13'h0123));
    $display("write test done");
    start();
    send(8'hd5, ak);
    chk(ak, 0, "foreign type acked");
    stop();
    sel = 3'h2;
    q(8);
    start();
    send(8'h6b, ak);
    chk(ak, 0, "foreign select acked");
    stop();
    sel = 3'h5;
    q(8);
    start();
    send(8'h08, ak);
    chk(ak, 0, "hs code acked");
    chk(hs_mode, 1, "hs entry");
    rd(13'h0124, 2, 1'b0, fx(13'h0124));
    chk(hs_mode, 0, "hs exit");
    $display("hs test done");
    start();
    send(8'h08, ak);
    chk(hs_mode, 1, "hs before reset");
    rst_n = 1'b0;
    q(2);
    chk({sda_oe, hs_mode, fetch_valid, src_ready}, 4'h1, "mid-run reset values");
    scl_m = 1'b1;
    q(4);
    rst_n = 1'b1;
    q(8);
    rd(13'h1fff, 2, 1'b1, fx(13'h1fff));
    $display("second reset test done");
    final_report();
  end
endmodule
